// ---- hdl/proximity_status_readout.sv ----
`timescale 1ns/1ps
`default_nettype none
module proximity_status_readout (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic conv_done,
  input wire prox_pkg::conv_t conv,
  input wire logic sense_enable,
  input wire logic irq_pin_enable,
  input wire logic [1:0] event_persistence,
  output logic [1:0] background_overflow_setting,
  output logic irq_out_n,
  output logic irq_out_oe
);
  typedef enum {st_idle, st_addr, st_addr_ack, st_wbyte, st_wack, st_rbyte, st_rack} st_t;

  logic [1:0] scl_s_r, sda_s_r;
  logic scl_d_r, sda_d_r;
  logic [1:0] scl_s_nxt, sda_s_nxt;
  always_comb begin
    scl_s_nxt = {scl_s_r[0], scl_in};
    sda_s_nxt = {sda_s_r[0], sda_in};
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'h1;
      sda_d_r <= 1'h1;
    end else begin
      scl_s_r <= scl_s_nxt;
      sda_s_r <= sda_s_nxt;
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end
  wire logic scl = scl_s_r[1];
  wire logic sda = sda_s_r[1];
  wire logic scl_rise = scl & ~scl_d_r;
  wire logic scl_fall = ~scl & scl_d_r;
  wire logic start_c = scl & scl_d_r & ~sda & sda_d_r;
  wire logic stop_c = scl & scl_d_r & sda & ~sda_d_r;

  // Sensing-side state
  logic [15:0] result_r, result_nxt;
  logic [15:0] snap_r, snap_nxt;
  logic event_r, event_nxt, near_r, near_nxt, bof_r, bof_nxt, valid_r, valid_nxt;
  logic [3:0] trip_cnt_r, trip_cnt_nxt;
  logic [7:0] bg_ctrl_r, bg_ctrl_nxt;

  // Bus-side state
  st_t st_r, st_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic rw_r, rw_nxt;
  logic first_r, first_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic sda_o_r, sda_o_nxt;
  logic snap_ok_r, snap_ok_nxt;
  logic full_r, full_nxt;

  logic clear_event, read_result;
  logic trip, trip_level;
  logic [3:0] need;
  logic [7:0] rd_byte;

  always_comb begin
    case (event_persistence)
      2'h2: need = prox_pkg::persist_four;
      2'h3: need = prox_pkg::persist_eight;
      default: need = 4'h1;
    endcase
    // Under overflow the zeroed result counts as below the low threshold
    trip_level = conv.background_overflow_flag ? 1'b1 : (conv.trip_high | conv.trip_low);
    trip = (event_persistence == 2'h0) | trip_level;
  end

  always_comb begin
    case (ptr_r)
      prox_pkg::reg_low: rd_byte = snap_ok_r ? snap_r[7:0] : result_r[7:0];
      prox_pkg::reg_high: rd_byte = snap_ok_r ? snap_r[15:8] : result_r[15:8];
      prox_pkg::reg_flags: begin
        rd_byte = 8'h00;
        rd_byte[prox_pkg::flag_event_bit] = event_r;
        rd_byte[prox_pkg::flag_near_bit] = near_r;
        rd_byte[prox_pkg::flag_bof_bit] = bof_r;
        rd_byte[prox_pkg::flag_valid_bit] = valid_r;
      end
      prox_pkg::reg_bg_ctrl: rd_byte = bg_ctrl_r;
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    shift_nxt = shift_r;
    bit_nxt = bit_r;
    rw_nxt = rw_r;
    first_nxt = first_r;
    ptr_nxt = ptr_r;
    sda_o_nxt = sda_o_r;
    snap_nxt = snap_r;
    snap_ok_nxt = snap_ok_r;
    full_nxt = full_r;
    bg_ctrl_nxt = bg_ctrl_r;
    clear_event = 1'b0;
    read_result = 1'b0;
    if (start_c) begin
      st_nxt = st_addr;
      bit_nxt = 3'h7;
      full_nxt = 1'b0;
      sda_o_nxt = 1'b0;
      // A transaction freezes both result bytes together
      snap_nxt = result_r;
      snap_ok_nxt = 1'b1;
    end else if (stop_c) begin
      st_nxt = st_idle;
      sda_o_nxt = 1'b0;
      snap_ok_nxt = 1'b0;
    end else begin
      case (st_r)
        st_idle: sda_o_nxt = 1'b0;
        st_addr, st_wbyte: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda};
            bit_nxt = bit_r - 3'h1;
            // The fall right after START must not be taken for a full byte
            full_nxt = (bit_r == 3'h0);
          end
          if (scl_fall && full_r) begin
            full_nxt = 1'b0;
            if (st_r == st_addr) begin
              if (shift_r[7:1] == prox_pkg::dev_addr) begin
                rw_nxt = shift_r[0];
                first_nxt = 1'b1;
                sda_o_nxt = 1'b1;
                st_nxt = st_addr_ack;
              end else begin
                st_nxt = st_idle;
              end
            end else begin
              sda_o_nxt = 1'b1;
              st_nxt = st_wack;
              if (first_r) begin
                first_nxt = 1'b0;
                if (shift_r == prox_pkg::cmd_clear_event) begin
                  clear_event = 1'b1;
                end else begin
                  ptr_nxt = shift_r;
                end
              end else begin
                if (ptr_r == prox_pkg::reg_bg_ctrl) begin
                  // Reserved bits are held at zero whatever is written
                  bg_ctrl_nxt = shift_r & prox_pkg::bg_ctrl_mask;
                end
                ptr_nxt = ptr_r + 8'h01;
              end
            end
          end
        end
        st_addr_ack, st_wack: begin
          if (scl_fall) begin
            bit_nxt = 3'h7;
            if (st_r == st_addr_ack && rw_r) begin
              st_nxt = st_rbyte;
              shift_nxt = rd_byte;
              sda_o_nxt = ~rd_byte[7];
              if (ptr_r == prox_pkg::reg_high || ptr_r == prox_pkg::reg_low) begin
                read_result = 1'b1;
              end
            end else begin
              st_nxt = st_wbyte;
              sda_o_nxt = 1'b0;
            end
          end
        end
        st_rbyte: begin
          if (scl_fall) begin
            if (bit_r == 3'h0) begin
              sda_o_nxt = 1'b0;
              st_nxt = st_rack;
              ptr_nxt = ptr_r + 8'h01;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              sda_o_nxt = ~shift_r[6];
            end
            bit_nxt = bit_r - 3'h1;
          end
        end
        st_rack: begin
          if (scl_rise && sda) begin
            st_nxt = st_idle;
          end else if (scl_fall) begin
            st_nxt = st_rbyte;
            bit_nxt = 3'h7;
            shift_nxt = rd_byte;
            sda_o_nxt = ~rd_byte[7];
            if (ptr_r == prox_pkg::reg_high || ptr_r == prox_pkg::reg_low) begin
              read_result = 1'b1;
            end
          end
        end
        default: st_nxt = st_idle;
      endcase
    end
  end

  always_comb begin
    result_nxt = result_r;
    event_nxt = event_r;
    near_nxt = near_r;
    bof_nxt = bof_r;
    valid_nxt = valid_r;
    trip_cnt_nxt = trip_cnt_r;
    if (read_result || !sense_enable) begin
      valid_nxt = 1'b0;
    end
    if (clear_event) begin
      event_nxt = 1'b0;
    end
    if (conv_done && sense_enable) begin
      bof_nxt = conv.background_overflow_flag;
      result_nxt = conv.background_overflow_flag ? 16'h0000 : conv.result;
      valid_nxt = 1'b1;
      if (conv.background_overflow_flag || conv.trip_low) begin
        near_nxt = 1'b0;
      end else if (conv.trip_high) begin
        near_nxt = 1'b1;
      end
      if (trip) begin
        if (trip_cnt_r + 4'h1 >= need) begin
          event_nxt = 1'b1;
          trip_cnt_nxt = 4'h0;
        end else begin
          trip_cnt_nxt = trip_cnt_r + 4'h1;
        end
      end else begin
        trip_cnt_nxt = 4'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= st_idle;
      shift_r <= prox_pkg::reset_byte;
      bit_r <= 3'h7;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      ptr_r <= prox_pkg::reset_byte;
      sda_o_r <= 1'b0;
      snap_r <= 16'h0000;
      snap_ok_r <= 1'b0;
      full_r <= 1'b0;
      bg_ctrl_r <= prox_pkg::reset_byte;
      result_r <= 16'h0000;
      event_r <= 1'b0;
      near_r <= 1'b0;
      bof_r <= 1'b0;
      valid_r <= 1'b0;
      trip_cnt_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      shift_r <= shift_nxt;
      bit_r <= bit_nxt;
      rw_r <= rw_nxt;
      first_r <= first_nxt;
      ptr_r <= ptr_nxt;
      sda_o_r <= sda_o_nxt;
      snap_r <= snap_nxt;
      snap_ok_r <= snap_ok_nxt;
      full_r <= full_nxt;
      bg_ctrl_r <= bg_ctrl_nxt;
      result_r <= result_nxt;
      event_r <= event_nxt;
      near_r <= near_nxt;
      bof_r <= bof_nxt;
      valid_r <= valid_nxt;
      trip_cnt_r <= trip_cnt_nxt;
    end
  end

  // Open drain: enable means pulling low
  always_comb begin
    sda_out = 1'b0;
    sda_oe = sda_o_r;
    irq_out_n = 1'b0;
    irq_out_oe = irq_pin_enable & event_r;
    background_overflow_setting = bg_ctrl_r[prox_pkg::bg_set_lsb +: 2];
  end
endmodule : proximity_status_readout
`default_nettype wire

// ---- hdl/prox_pkg.sv ----
package prox_pkg;
  localparam logic [6:0] dev_addr = 7'h39;
  localparam logic [7:0] reg_low = 8'h12;
  localparam logic [7:0] reg_high = 8'h13;
  localparam logic [7:0] reg_flags = 8'h18;
  localparam logic [7:0] reg_bg_ctrl = 8'h25;
  // Special-function byte that clears the event flag
  localparam logic [7:0] cmd_clear_event = 8'hE1;
  localparam int flag_event_bit = 3;
  localparam int flag_near_bit = 2;
  localparam int flag_bof_bit = 1;
  localparam int flag_valid_bit = 0;
  localparam int bg_set_lsb = 4;
  localparam logic [7:0] bg_ctrl_mask = 8'h30;
  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [3:0] persist_four = 4'h4;
  localparam logic [3:0] persist_eight = 4'h8;

  // One finished conversion from the sensing engine
  typedef struct packed {
    logic [15:0] result;
    logic background_overflow_flag;
    logic trip_high;
    logic trip_low;
  } conv_t;
endpackage : prox_pkg

// ---- bench/prox_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module prox_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic conv_done,
  input wire prox_pkg::conv_t conv,
  input wire logic sense_enable,
  input wire logic irq_pin_enable,
  input wire logic [1:0] event_persistence,
  input wire logic [1:0] background_overflow_setting,
  input wire logic irq_out_n,
  input wire logic irq_out_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  property p_pins; sda_out == 1'b0 && irq_out_n == 1'b0; endproperty
  a_pins: assert property (p_pins) else $error("pin level");
  property p_rst;
    $rose(resetn) |-> !sda_oe && !irq_out_oe && background_overflow_setting == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_off; !irq_pin_enable && !$past(irq_pin_enable) |-> !irq_out_oe; endproperty
  a_off: assert property (p_off) else $error("irq while off");
  property p_en; irq_out_oe |-> irq_pin_enable || $past(irq_pin_enable); endproperty
  a_en: assert property (p_en) else $error("irq without enable");
  property p_every;
    conv_done && sense_enable && event_persistence == 2'h0 ##1 irq_pin_enable[*2] |-> irq_out_oe;
  endproperty
  a_every: assert property (p_every) else $error("event not set");
  // SDA may only move while SCL is low, or it would fake a START or STOP
  property p_sda; $changed(sda_oe) |-> !scl_in; endproperty
  a_sda: assert property (p_sda) else $error("sda moved on high scl");
  property p_gate;
    (!sense_enable && irq_pin_enable)[*4] ##0 !irq_out_oe |=> !irq_out_oe;
  endproperty
  a_gate: assert property (p_gate) else $error("event while disabled");
  property p_hold;
    (irq_out_oe && irq_pin_enable && scl_in && sda_in)[*8] |=> irq_out_oe || !irq_pin_enable;
  endproperty
  a_hold: assert property (p_hold) else $error("event dropped");
  c_irq: cover property (irq_out_oe && irq_pin_enable);
  c_ack: cover property ($rose(sda_oe));
  c_bg: cover property (background_overflow_setting != 2'h0);
endmodule : prox_sva
bind proximity_status_readout prox_sva u_sva (.clk(clk), .resetn(resetn), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .conv_done(conv_done), .conv(conv),
  .sense_enable(sense_enable), .irq_pin_enable(irq_pin_enable),
  .event_persistence(event_persistence),
  .background_overflow_setting(background_overflow_setting), .irq_out_n(irq_out_n),
  .irq_out_oe(irq_out_oe));
`default_nettype wire

// ---- bench/i2c_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic clk,
  input wire logic dev_pull,
  output logic scl,
  output wire logic sda
);
  logic low_r = 1'b0;
  initial scl = 1'b1;
  // Pull-up: a released line reads high, never a stale value
  assign sda = !(low_r || dev_pull);
  task automatic sl(input logic c, input logic l, input int n);
    scl = c;
    low_r = l;
    repeat (n) @(negedge clk);
  endtask : sl
  task automatic bx(input logic b, output logic r);
    sl(1'b0, !b, 4);
    sl(1'b1, !b, 8);
    r = sda;
    sl(1'b0, !b, 4);
  endtask : bx
  task automatic xb(input logic [7:0] d, input logic l, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
    bx(l, a);
  endtask : xb
  task automatic start();
    sl(1'b0, 1'b0, 4);
    sl(1'b1, 1'b0, 8);
    sl(1'b1, 1'b1, 8);
    sl(1'b0, 1'b1, 4);
  endtask : start
  task automatic stop();
    sl(1'b0, 1'b1, 4);
    sl(1'b1, 1'b1, 8);
    sl(1'b1, 1'b0, 8);
  endtask : stop
  task automatic wr(input logic [6:0] ad, input logic [7:0] p, input logic [7:0] d,
      input logic wd, output logic ok);
    logic [7:0] q;
    logic a;
    start();
    xb({ad, 1'b0}, 1'b1, q, a);
    ok = !a;
    xb(p, 1'b1, q, a);
    if (wd) xb(d, 1'b1, q, a);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [7:0] q0, output logic [7:0] q1);
    logic [7:0] q;
    logic a;
    start();
    xb({prox_pkg::dev_addr, 1'b0}, 1'b1, q, a);
    xb(p, 1'b1, q, a);
    start();
    xb({prox_pkg::dev_addr, 1'b1}, 1'b1, q, a);
    xb(8'hFF, 1'b0, q0, a);
    xb(8'hFF, 1'b1, q1, a);
    stop();
  endtask : rd
endmodule : i2c_host_model
`default_nettype wire

// ---- bench/tb_proximity_status_readout.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_proximity_status_readout;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic conv_done = 1'b0;
  prox_pkg::conv_t conv = '0;
  logic sense_enable = 1'b1;
  logic irq_pin_enable = 1'b1;
  logic [1:0] event_persistence = 2'h0;
  logic [1:0] bg_set;
  logic sda_oe;
  logic irq_oe;
  logic scl;
  wire logic sda;
  logic ok;
  logic [7:0] q0;
  logic [7:0] q1;
  int pn [4] = '{0, 1, 4, 8};
  int n_errors = 0;
  int checks = 0;
  initial begin
    forever #10 clk = ~clk;
  end
  i2c_host_model u_host (.clk(clk), .dev_pull(sda_oe), .scl(scl), .sda(sda));
  proximity_status_readout u_dut (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .conv_done(conv_done), .conv(conv),
    .sense_enable(sense_enable), .irq_pin_enable(irq_pin_enable),
    .event_persistence(event_persistence), .background_overflow_setting(bg_set),
    .irq_out_n(), .irq_out_oe(irq_oe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] p, input logic [7:0] e);
    u_host.rd(p, q0, q1);
    chk(q0, e);
  endtask : rc
  task automatic cv(input logic [15:0] r, input logic [2:0] f);
    @(negedge clk);
    conv_done = 1'b1;
    conv = {r, f};
    @(negedge clk);
    conv_done = 1'b0;
    repeat (3) @(negedge clk);
  endtask : cv
  task automatic clr();
    u_host.wr(prox_pkg::dev_addr, prox_pkg::cmd_clear_event, 8'h00, 1'b0, ok);
  endtask : clr
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    test_done();
  end
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    rc(prox_pkg::reg_flags, 8'h00);
    rc(prox_pkg::reg_high, 8'h00);
    rc(prox_pkg::reg_bg_ctrl, 8'h00);
    u_host.wr(7'h3A, prox_pkg::reg_bg_ctrl, 8'h30, 1'b1, ok);
    chk({7'h0, ok}, 8'h00);
    u_host.wr(prox_pkg::dev_addr, prox_pkg::reg_bg_ctrl, 8'h20, 1'b1, ok);
    chk({6'h0, bg_set}, 8'h02);
    rc(prox_pkg::reg_bg_ctrl, 8'h20);
    $display("register test done");
    cv(16'hA5C3, 3'b010);
    chk({7'h0, irq_oe}, 8'h01);
    irq_pin_enable = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h0, irq_oe}, 8'h00);
    irq_pin_enable = 1'b1;
    rc(prox_pkg::reg_flags, 8'h0D);
    rc(prox_pkg::reg_low, 8'hC3);
    chk(q1, 8'hA5);
    rc(prox_pkg::reg_flags, 8'h0C);
    clr();
    rc(prox_pkg::reg_flags, 8'h04);
    cv(16'h1234, 3'b100);
    rc(prox_pkg::reg_flags, 8'h0B);
    rc(prox_pkg::reg_low, 8'h00);
    chk(q1, 8'h00);
    $display("conversion test done");
    // A quiet conversion first, so trips left from earlier do not count
    for (int k = 1; k < 4; k++) begin
      event_persistence = k[1:0];
      cv(16'h0100, 3'b000);
      clr();
      repeat (pn[k] - 1) cv(16'hF000, 3'b010);
      chk({7'h0, irq_oe}, 8'h00);
      cv(16'hF000, 3'b010);
      chk({7'h0, irq_oe}, 8'h01);
    end
    $display("persistence test done");
    event_persistence = 2'h0;
    clr();
    sense_enable = 1'b0;
    cv(16'h0100, 3'b010);
    rc(prox_pkg::reg_flags, 8'h04);
    $display("sense gate test done");
    sense_enable = 1'b1;
    cv(16'h0010, 3'b001);
    rc(prox_pkg::reg_flags, 8'h09);
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    chk({6'h0, bg_set}, 8'h00);
    rc(prox_pkg::reg_flags, 8'h00);
    $display("low trip and reset test done");
    test_done();
  end
endmodule : tb_proximity_status_readout
`default_nettype wire
